// ### oag_core.sv
// operand fetch and effective address generation unit
module oag_core (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // command from the decoder
  input  wire logic                 cmd_valid,
  output      logic                 cmd_ready,
  input  wire oag_pkg::oag_mode_type cmd_mode,
  input  wire logic [7:0]           cmd_opcode,
  input  wire logic [15:0]          cmd_pc,
  input  wire logic                 cmd_index_sel,
  input  wire logic [1:0]           cmd_pair,
  input  wire logic                 cmd_imm_src,
  input  wire logic                 cmd_load,
  input  wire logic                 cmd_wide,
  input  wire logic                 cmd_block_dec,
  input  wire logic                 cmd_bit,
  // register file values
  input  wire logic [15:0]          first_index_register,
  input  wire logic [15:0]          second_index_register,
  input  wire logic [15:0]          primary_pointer_pair,
  input  wire logic [15:0]          pair_bc,
  input  wire logic [15:0]          pair_de,
  input  wire logic [7:0]           accumulator,
  // memory read port
  output      logic                 mem_req,
  output      logic [15:0]          mem_addr,
  input  wire logic [7:0]           mem_rdata,
  input  wire logic                 mem_ack,
  // results
  output      logic                 res_valid,
  output      logic [15:0]          res_ea,
  output      logic [15:0]          res_operand,
  output      logic [15:0]          res_target,
  output      logic [15:0]          res_next_pc,
  output      logic [2:0]           res_src_reg,
  output      logic [2:0]           res_dst_reg,
  output      logic [2:0]           res_bit_sel,
  output      logic                 res_bit_op,
  output      logic                 res_dest_acc,
  output      logic [15:0]          res_src_ptr,
  output      logic [15:0]          res_dst_ptr,
  output      logic [15:0]          res_count,
  output      logic                 res_match,
  output      logic                 res_count_zero
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_DISP,
    S_OP_LO,
    S_OP_HI,
    S_MEM_LO,
    S_MEM_HI,
    S_DONE
  } oag_state_type;

  oag_state_type         state;
  oag_state_type         next_state;
  oag_pkg::oag_mode_type mode;
  logic [7:0]            op;
  logic                  idx_sel;
  logic                  imm_src;
  logic                  load;
  logic                  wide;
  logic                  dec;
  logic                  bit_op;
  logic [15:0]           cursor;
  logic [15:0]           next_cursor;
  logic [15:0]           ea;
  logic [15:0]           next_ea;
  logic [15:0]           target;
  logic [15:0]           next_target;
  logic [15:0]           operand;
  logic [15:0]           next_operand;
  logic [15:0]           next_mem_addr;
  logic [7:0]            cmp_value;
  logic                  match;
  logic [15:0]           count_left;
  logic [15:0]           next_count;

  // entry state depends on which bytes the mode must fetch
  function automatic oag_state_type entry_state(
    input oag_pkg::oag_mode_type m,
    input logic                  imm,
    input logic                  ld
  );
    oag_state_type s;
    s = S_DONE;
    unique case (m)
      oag_pkg::MODE_IMM,
      oag_pkg::MODE_IMM_EXT,
      oag_pkg::MODE_EXTENDED:     s = S_OP_LO;
      oag_pkg::MODE_RELATIVE,
      oag_pkg::MODE_INDEXED:      s = S_DISP;
      oag_pkg::MODE_REG_INDIRECT: s = imm ? S_OP_LO : (ld ? S_MEM_LO : S_DONE);
      oag_pkg::MODE_BLOCK:        s = S_MEM_LO;
      default:                    s = S_DONE;
    endcase
    return s;
  endfunction

  // handshake decode
  wire start       = cmd_valid & cmd_ready;
  wire fetch_state = (state == S_DISP) || (state == S_OP_LO) ||
                     (state == S_OP_HI) || (state == S_MEM_LO) ||
                     (state == S_MEM_HI);
  wire step        = fetch_state & mem_ack;
  wire stream_step = step & ((state == S_DISP) || (state == S_OP_LO) ||
                             (state == S_OP_HI));
  wire is_rel      = (mode == oag_pkg::MODE_RELATIVE);
  wire is_idx      = (mode == oag_pkg::MODE_INDEXED);
  wire is_ext      = (mode == oag_pkg::MODE_EXTENDED);
  wire is_blk      = (mode == oag_pkg::MODE_BLOCK);

  assign cmd_ready = (state == S_IDLE);
  assign mem_req   = fetch_state;
  assign res_valid = (state == S_DONE);

  // pointer pair chosen at command time for indirect access
  wire [15:0] pair_value = (cmd_pair == oag_pkg::PAIR_BC) ? pair_bc :
                           (cmd_pair == oag_pkg::PAIR_DE) ? pair_de :
                           primary_pointer_pair;

  // index registers are only read here, never written back
  wire [15:0] index_value = idx_sel ? second_index_register
                                    : first_index_register;

  // one adder serves relative and indexed: base is opcode+2 or index
  wire [15:0] add_base = is_rel ? oag_pkg::oag_inc(cursor)
                                : index_value;
  wire [15:0] add_sum;

  oag_ea_adder u_adder (
    .base (add_base),
    .disp (mem_rdata),
    .sum  (add_sum)
  );

  // sequencing of the operand bytes
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE:   if (start) next_state = entry_state(cmd_mode, cmd_imm_src,
                                                    cmd_load);
      S_DISP:   if (mem_ack) begin
        if (is_idx && imm_src) next_state = S_OP_LO;
        else if (is_idx && load) next_state = S_MEM_LO;
        else next_state = S_DONE;
      end
      S_OP_LO:  if (mem_ack) begin
        if (mode == oag_pkg::MODE_IMM_EXT || is_ext) next_state = S_OP_HI;
        else next_state = S_DONE;
      end
      S_OP_HI:  if (mem_ack) next_state = (is_ext && load) ? S_MEM_LO
                                                            : S_DONE;
      S_MEM_LO: if (mem_ack) next_state = wide ? S_MEM_HI : S_DONE;
      S_MEM_HI: if (mem_ack) next_state = S_DONE;
      S_DONE:   next_state = S_IDLE;
    endcase
  end

  // instruction-stream cursor starts just past the opcode
  assign next_cursor = start ? oag_pkg::oag_inc(cmd_pc) :
                       stream_step ? oag_pkg::oag_inc(cursor) : cursor;

  // effective address: pair, index sum or absolute word
  always_comb begin
    next_ea = ea;
    if (start && cmd_mode == oag_pkg::MODE_REG_INDIRECT) begin
      next_ea = pair_value;
    end else if (start && cmd_mode == oag_pkg::MODE_BLOCK) begin
      next_ea = primary_pointer_pair;
    end else if (step && state == S_DISP && is_idx) begin
      next_ea = add_sum;
    end else if (step && state == S_OP_HI && is_ext) begin
      next_ea = {mem_rdata, operand[7:0]};
    end
  end

  // jump target: restart, relative sum or absolute word
  always_comb begin
    next_target = target;
    if (start && cmd_mode == oag_pkg::MODE_RESTART) begin
      next_target = oag_pkg::oag_restart(cmd_opcode);
    end else if (step && state == S_DISP && is_rel) begin
      next_target = add_sum;
    end else if (step && state == S_OP_HI && is_ext) begin
      next_target = {mem_rdata, operand[7:0]};
    end
  end

  // operand assembly, low byte first in both stream and memory
  always_comb begin
    next_operand = operand;
    if (start) begin
      next_operand = oag_pkg::WORD_RESET;
    end else if (step) begin
      unique case (state)
        S_OP_LO,
        S_MEM_LO: next_operand = {oag_pkg::BYTE_ZERO, mem_rdata};
        S_OP_HI,
        S_MEM_HI: next_operand = {mem_rdata, operand[7:0]};
        default:  next_operand = operand;
      endcase
    end
  end

  // address presented for the next fetch
  always_comb begin
    unique case (next_state)
      S_MEM_LO: next_mem_addr = next_ea;
      S_MEM_HI: next_mem_addr = oag_pkg::oag_inc(next_ea);
      default:  next_mem_addr = next_cursor;
    endcase
  end

  // block step: count decrements once per byte read
  assign next_count = (step && state == S_MEM_LO && is_blk) ?
                      count_left - oag_pkg::WORD_ONE : count_left;

  // sequencer and address registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= S_IDLE;
      cursor   <= oag_pkg::ADDR_RESET;
      ea       <= oag_pkg::ADDR_RESET;
      target   <= oag_pkg::ADDR_RESET;
      operand  <= oag_pkg::WORD_RESET;
      mem_addr <= oag_pkg::ADDR_RESET;
    end else begin
      state    <= next_state;
      cursor   <= next_cursor;
      ea       <= next_ea;
      target   <= next_target;
      operand  <= next_operand;
      mem_addr <= next_mem_addr;
    end
  end

  // command fields held for the whole sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      mode      <= oag_pkg::MODE_IMPLIED;
      op        <= oag_pkg::BYTE_ZERO;
      idx_sel   <= 1'b0;
      imm_src   <= 1'b0;
      load      <= 1'b0;
      wide      <= 1'b0;
      dec       <= 1'b0;
      bit_op    <= 1'b0;
      cmp_value <= oag_pkg::BYTE_ZERO;
    end else if (start) begin
      mode      <= cmd_mode;
      op        <= cmd_opcode;
      idx_sel   <= cmd_index_sel;
      imm_src   <= cmd_imm_src;
      load      <= cmd_load;
      wide      <= cmd_wide;
      dec       <= cmd_block_dec;
      bit_op    <= cmd_bit;
      cmp_value <= accumulator;
    end
  end

  // block pointers and compare, updated when the source byte lands
  always_ff @(posedge clk) begin
    if (rst) begin
      res_src_ptr <= oag_pkg::ADDR_RESET;
      res_dst_ptr <= oag_pkg::ADDR_RESET;
      count_left  <= oag_pkg::WORD_RESET;
      match       <= 1'b0;
    end else if (start) begin
      res_src_ptr <= primary_pointer_pair;
      res_dst_ptr <= pair_de;
      count_left  <= pair_bc;
      match       <= 1'b0;
    end else if (step && state == S_MEM_LO && is_blk) begin
      res_src_ptr <= oag_pkg::oag_step(ea, dec);
      res_dst_ptr <= oag_pkg::oag_step(res_dst_ptr, dec);
      count_left  <= next_count;
      match       <= (mem_rdata == cmp_value);
    end
  end

  // result wiring from held registers; fields only mean something
  // for the modes that use them
  assign res_ea         = ea;
  assign res_operand    = operand;
  assign res_target     = target;
  assign res_next_pc    = cursor;
  assign res_count      = count_left;
  assign res_match      = match;
  assign res_count_zero = (count_left == oag_pkg::WORD_RESET);
  assign res_src_reg    = op[oag_pkg::SRC_FIELD_LSB +: 3];
  assign res_dst_reg    = op[oag_pkg::DST_FIELD_LSB +: 3];
  assign res_bit_sel    = op[oag_pkg::BIT_FIELD_LSB +: 3];
  assign res_bit_op     = bit_op & ((mode == oag_pkg::MODE_REGISTER) ||
                          (mode == oag_pkg::MODE_REG_INDIRECT) ||
                          is_idx);
  assign res_dest_acc   = (mode == oag_pkg::MODE_IMPLIED);

  // checks on the generated addresses and operands
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ext_lo;
    state == S_OP_LO && mem_ack && mode == oag_pkg::MODE_IMM_EXT;
  endsequence

  sequence s_ext_hi;
    state == S_OP_HI && mem_ack;
  endsequence

  chk_imm_byte: assert property (
    state == S_OP_LO && mem_ack && mode == oag_pkg::MODE_IMM |=>
      res_valid && res_operand == {8'h00, $past(mem_rdata)})
    else $error("immediate operand differs from fetched byte");

  chk_ext_order: assert property (
    s_ext_lo ##1 s_ext_hi |=>
      res_valid && res_operand == {$past(mem_rdata), $past(mem_rdata, 2)})
    else $error("extended immediate bytes assembled in wrong order");

  chk_restart_target: assert property (
    start && cmd_mode == oag_pkg::MODE_RESTART |=>
      res_valid && res_target == {10'h000, $past(cmd_opcode[5:3]), 3'h0})
    else $error("restart target not in page zero slot");

  chk_rel_target: assert property (
    state == S_DISP && mem_ack && is_rel |=>
      res_valid && res_target == 16'($past(cursor) + 16'h0001 +
                                     {{8{$past(mem_rdata[7])}},
                                      $past(mem_rdata)}))
    else $error("relative target is not opcode plus two plus disp");

  chk_idx_sum: assert property (
    state == S_DISP && mem_ack && is_idx |=>
      ea == 16'($past(index_value) + {{8{$past(mem_rdata[7])}},
                                      $past(mem_rdata)}))
    else $error("indexed address is not index plus signed disp");

  chk_hi_addr: assert property (
    state == S_MEM_HI |-> mem_req && mem_addr == 16'(ea + 16'h0001))
    else $error("high byte not fetched at pointer plus one");

  chk_ptr_addr: assert property (
    start && cmd_mode == oag_pkg::MODE_REG_INDIRECT && cmd_load &&
    !cmd_imm_src |=> state == S_MEM_LO && mem_addr == $past(pair_value))
    else $error("indirect fetch not at register pair address");

  chk_block_step: assert property (
    state == S_MEM_LO && mem_ack && is_blk |=>
      res_src_ptr == (dec ? 16'(ea - 16'h0001) : 16'(ea + 16'h0001)) &&
      res_count == 16'($past(count_left) - 16'h0001) ##1 !res_valid)
    else $error("block pointer or count stepped wrongly");

  chk_req_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped before acknowledge");

  chk_implied_acc: assert property (
    start && cmd_mode == oag_pkg::MODE_IMPLIED |=> res_valid && res_dest_acc)
    else $error("implied result not steered to accumulator");

endmodule

// ### oag_mem_model.sv
// memory partner that answers the operand unit's byte reads
module oag_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // byte read port
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output      logic [7:0]  mem_rdata,
  output      logic        mem_ack,
  // delay in cycles before each byte is answered
  input  wire logic [3:0]  wait_cycles
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:65535];
  logic [3:0] waited;
  logic [7:0] last;

  // untouched locations hold a marker so a stray read shows in results
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hEE;
    end
  end

  // between answers the data lines carry the inverse of the last byte,
  // so a sample taken outside the acknowledge cannot pass by luck
  assign mem_ack   = mem_req && (waited == wait_cycles);
  assign mem_rdata = mem_ack ? mem[mem_addr] : ~last;

  // delay counter restarts for every byte
  always_ff @(posedge clk) begin
    if (rst) begin
      waited <= 4'h0;
      last   <= 8'h00;
    end else if (mem_ack) begin
      waited <= 4'h0;
      last   <= mem_rdata;
    end else if (mem_req) begin
      waited <= waited + 4'h1;
    end
  end
endmodule

// ### oag_pkg.sv
// constants, mode type and address arithmetic for the operand address unit
// Summary of operation
// - immediate: operand is byte after opcode
// - immediate extended: low byte, then high byte
// - restart loads one of eight page-zero targets
// - relative: signed byte added to next opcode
// - relative reach +127..-128 from opcode plus two
// - extended: two-byte absolute jump or operand address
// - indexed: displacement plus selected index register
// - indexed address leaves index register unchanged
// - indexed displacement is signed two's complement
// - register operand decoded from opcode bit field
// - implied arithmetic always targets the accumulator
// - register indirect: register pair is the pointer
// - wide operand: low at pointer, high pointer+1
// - block ops step pointers and compare each byte
// - bit ops: three opcode bits pick one bit
// - source and destination modes may differ
package oag_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // opcode field positions, each field three bits wide
  localparam int SRC_FIELD_LSB = 0;
  localparam int DST_FIELD_LSB = 3;
  localparam int BIT_FIELD_LSB = 3;
  localparam int RST_FIELD_LSB = 3;

  // register pair selection for register indirect mode
  localparam logic [1:0] PAIR_PRIMARY = 2'h0;
  localparam logic [1:0] PAIR_BC      = 2'h1;
  localparam logic [1:0] PAIR_DE      = 2'h2;

  // reset values and the unit step
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [15:0] WORD_ONE   = 16'h0001;

  typedef enum logic [3:0] {
    MODE_IMM,
    MODE_IMM_EXT,
    MODE_RESTART,
    MODE_RELATIVE,
    MODE_EXTENDED,
    MODE_INDEXED,
    MODE_REGISTER,
    MODE_IMPLIED,
    MODE_REG_INDIRECT,
    MODE_BLOCK
  } oag_mode_type;

  // sign extension of a displacement byte
  function automatic logic [15:0] oag_sext(input logic [7:0] d);
    return {{8{d[7]}}, d};
  endfunction

  // next byte address, wrapping at the top of the space
  function automatic logic [15:0] oag_inc(input logic [15:0] a);
    return a + WORD_ONE;
  endfunction

  // pointer step for block operations
  function automatic logic [15:0] oag_step(input logic [15:0] a,
                                           input logic        dec);
    return dec ? a - WORD_ONE : a + WORD_ONE;
  endfunction

  // page-zero restart target from the opcode
  function automatic logic [15:0] oag_restart(input logic [7:0] op);
    return {10'h000, op[RST_FIELD_LSB +: 3], 3'h0};
  endfunction

endpackage

// base plus signed displacement, wrapping in 16 bits
module oag_ea_adder (
  // operands
  input  wire logic [15:0] base,
  input  wire logic [7:0]  disp,
  // result
  output      logic [15:0] sum
);

  // carry out of bit 15 is dropped so the sum wraps
  assign sum = base + oag_pkg::oag_sext(disp);

endmodule

// ### operand_address_generator_test.sv
// self-checking bench for the operand address unit
module operand_address_generator_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    oag_pkg::oag_mode_type m;
    logic [7:0]            op;
    logic [15:0]           pc;
    logic [7:0]            f;
    logic [15:0]           ea;
    logic [15:0]           opnd;
    logic [15:0]           tgt;
    logic [15:0]           npc;
    logic [3:0]            sel;
  } oag_row_type;

  // design inputs
  logic                  clk, rst, cmd_valid, cmd_index_sel, cmd_imm_src;
  logic                  cmd_load, cmd_wide, cmd_block_dec, cmd_bit;
  oag_pkg::oag_mode_type cmd_mode;
  logic [7:0]            cmd_opcode, accumulator;
  logic [15:0]           cmd_pc, pair_bc, pair_de, primary_pointer_pair;
  logic [1:0]            cmd_pair;
  logic [15:0]           first_index_register, second_index_register;
  // design outputs and memory lines
  logic                  cmd_ready, mem_req, mem_ack, res_valid, res_bit_op;
  logic                  res_dest_acc, res_match, res_count_zero;
  logic [15:0]           mem_addr, res_ea, res_operand, res_target;
  logic [15:0]           res_next_pc, res_src_ptr, res_dst_ptr, res_count;
  logic [7:0]            mem_rdata;
  logic [2:0]            res_src_reg, res_dst_reg, res_bit_sel;
  // bench state
  logic [3:0]            wait_cycles;
  int                    n_fail, compares, cycles;
  oag_row_type           rows [14];

  // memory image: address in the upper 16 bits, byte in the lower 8
  localparam logic [23:0] POKES [23] = '{
    24'h01013C, 24'h020134, 24'h020212, 24'h03017F, 24'h040180, 24'hFFFF10,
    24'h050178, 24'h050256, 24'h060100, 24'h060270, 24'h7000CD, 24'h7001AB,
    24'h0701FE, 24'h0FFE11, 24'h08017F, 24'h006F22, 24'h007033, 24'h090105,
    24'h090299, 24'h200044, 24'h300066, 24'h300155, 24'h0B0177};

  oag_core dut (
    .clk, .rst, .cmd_valid, .cmd_ready, .cmd_mode, .cmd_opcode, .cmd_pc,
    .cmd_index_sel, .cmd_pair, .cmd_imm_src, .cmd_load, .cmd_wide,
    .cmd_block_dec, .cmd_bit, .first_index_register, .second_index_register,
    .primary_pointer_pair, .pair_bc, .pair_de, .accumulator, .mem_req,
    .mem_addr, .mem_rdata, .mem_ack, .res_valid, .res_ea, .res_operand,
    .res_target, .res_next_pc, .res_src_reg, .res_dst_reg, .res_bit_sel,
    .res_bit_op, .res_dest_acc, .res_src_ptr, .res_dst_ptr, .res_count,
    .res_match, .res_count_zero);

  oag_mem_model mem_i (
    .clk, .rst, .mem_req, .mem_addr, .mem_rdata, .mem_ack, .wait_cycles);

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // called at a clock edge; returns at the edge that samples res_valid
  task automatic issue(input oag_pkg::oag_mode_type m, input logic [7:0] op,
                       input logic [15:0] pc, input logic [7:0] f);
    int n;
    cmd_mode   <= m;
    cmd_opcode <= op;
    cmd_pc     <= pc;
    {cmd_bit, cmd_index_sel, cmd_pair, cmd_imm_src, cmd_load, cmd_wide,
     cmd_block_dec} <= f;
    cmd_valid  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (res_valid !== 1'b1 && n < 50);
    chk("res_valid", 16'h0001, res_valid);
  endtask

  task automatic run_row(input oag_row_type r);
    issue(r.m, r.op, r.pc, r.f);
    if (r.sel[3]) chk("res_ea", r.ea, res_ea);
    if (r.sel[2]) chk("res_operand", r.opnd, res_operand);
    if (r.sel[1]) chk("res_target", r.tgt, res_target);
    if (r.sel[0]) chk("res_next_pc", r.npc, res_next_pc);
  endtask

  // flag byte f: bit, index select, pair(2), imm, load, wide, decrement
  initial begin
    rows[0] = '{oag_pkg::MODE_IMM, 8'h3E, 16'h0100, 8'h00,
      16'h0000, 16'h003C, 16'h0000, 16'h0102, 4'h5};
    rows[1] = '{oag_pkg::MODE_IMM_EXT, 8'h21, 16'h0200, 8'h00,
      16'h0000, 16'h1234, 16'h0000, 16'h0203, 4'h5};
    rows[2] = '{oag_pkg::MODE_RELATIVE, 8'h18, 16'h0300, 8'h00,
      16'h0000, 16'h0000, 16'h0381, 16'h0302, 4'h3};
    rows[3] = '{oag_pkg::MODE_RELATIVE, 8'h18, 16'h0400, 8'h00,
      16'h0000, 16'h0000, 16'h0382, 16'h0402, 4'h3};
    rows[4] = '{oag_pkg::MODE_RELATIVE, 8'h18, 16'hFFFE, 8'h00,
      16'h0000, 16'h0000, 16'h0010, 16'h0000, 4'h3};
    rows[5] = '{oag_pkg::MODE_EXTENDED, 8'hC3, 16'h0500, 8'h00,
      16'h0000, 16'h5678, 16'h5678, 16'h0503, 4'h7};
    rows[6] = '{oag_pkg::MODE_EXTENDED, 8'h2A, 16'h0600, 8'h06,
      16'h7000, 16'hABCD, 16'h7000, 16'h0603, 4'hF};
    rows[7] = '{oag_pkg::MODE_INDEXED, 8'h7E, 16'h0700, 8'h04,
      16'h0FFE, 16'h0011, 16'h0000, 16'h0702, 4'hD};
    rows[8] = '{oag_pkg::MODE_INDEXED, 8'h7E, 16'h0800, 8'h46,
      16'h006F, 16'h3322, 16'h0000, 16'h0802, 4'hD};
    rows[9] = '{oag_pkg::MODE_INDEXED, 8'h36, 16'h0900, 8'h08,
      16'h1005, 16'h0099, 16'h0000, 16'h0903, 4'hD};
    rows[10] = '{oag_pkg::MODE_REG_INDIRECT, 8'h7E, 16'h0A00, 8'h04,
      16'h2000, 16'h0044, 16'h0000, 16'h0000, 4'hC};
    rows[11] = '{oag_pkg::MODE_REG_INDIRECT, 8'h0A, 16'h0A00, 8'h16,
      16'h3000, 16'h5566, 16'h0000, 16'h0000, 4'hC};
    rows[12] = '{oag_pkg::MODE_REG_INDIRECT, 8'h12, 16'h0A00, 8'h20,
      16'h4000, 16'h0000, 16'h0000, 16'h0000, 4'h8};
    // immediate source into a pointer destination: stream byte, no load
    rows[13] = '{oag_pkg::MODE_REG_INDIRECT, 8'h36, 16'h0B00, 8'h08,
      16'h2000, 16'h0077, 16'h0000, 16'h0B02, 4'hD};
    n_fail = 0;
    compares = 0;
    cycles = 0;
    rst <= 1'b1;
    cmd_valid <= 1'b0;
    cmd_mode <= oag_pkg::MODE_IMPLIED;
    cmd_opcode <= 8'h00;
    cmd_pc <= 16'h0000;
    {cmd_bit, cmd_index_sel, cmd_pair, cmd_imm_src, cmd_load, cmd_wide,
     cmd_block_dec} <= 8'h00;
    first_index_register <= 16'h1000;
    second_index_register <= 16'hFFF0;
    primary_pointer_pair <= 16'h2000;
    pair_bc <= 16'h3000;
    pair_de <= 16'h4000;
    accumulator <= 8'h5A;
    wait_cycles <= 4'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (POKES[i]) mem_i.mem[POKES[i][23:8]] = POKES[i][7:0];
    @(posedge clk);
    chk("cmd_ready", 16'h0001, cmd_ready);
    chk("mem_req", 16'h0000, mem_req);
    chk("res_dest_acc", 16'h0001, res_dest_acc);
    $display("test reset done");
    // table once with a prompt memory, once with a slow one
    for (int w = 0; w < 2; w++) begin
      wait_cycles <= (w == 0) ? 4'h0 : 4'h3;
      foreach (rows[i]) run_row(rows[i]);
    end
    $display("test table done");
    for (int s = 0; s < 8; s++) begin
      issue(oag_pkg::MODE_RESTART, {2'b11, 3'(s), 3'b111}, 16'h0C00, 8'h00);
      chk("res_target", {10'h000, 3'(s), 3'h0}, res_target);
    end
    for (int b = 0; b < 8; b++) begin
      issue(oag_pkg::MODE_REGISTER, {2'b01, 3'(b), 3'b010}, 16'h0D00, 8'h80);
      chk("res_bit_sel", {13'h0000, 3'(b)}, res_bit_sel);
      chk("res_bit_op", 16'h0001, res_bit_op);
      chk("res_dst_reg", {13'h0000, 3'(b)}, res_dst_reg);
      chk("res_src_reg", 16'h0002, res_src_reg);
      chk("res_dest_acc", 16'h0000, res_dest_acc);
    end
    issue(oag_pkg::MODE_IMPLIED, 8'h86, 16'h0D00, 8'h00);
    chk("res_dest_acc", 16'h0001, res_dest_acc);
    chk("res_bit_op", 16'h0000, res_bit_op);
    // bit operation on an indexed location
    issue(oag_pkg::MODE_INDEXED, 8'h46, 16'h0700, 8'h84);
    chk("res_bit_op", 16'h0001, res_bit_op);
    chk("res_bit_sel", 16'h0000, res_bit_sel);
    chk("res_operand", 16'h0011, res_operand);
    $display("test fields done");
    // block step up with no match, then down onto a match at count end
    issue(oag_pkg::MODE_BLOCK, 8'hA0, 16'h0E00, 8'h00);
    chk("res_src_ptr", 16'h2001, res_src_ptr);
    chk("res_dst_ptr", 16'h4001, res_dst_ptr);
    chk("res_count", 16'h2FFF, res_count);
    chk("res_count_zero", 16'h0000, res_count_zero);
    chk("res_match", 16'h0000, res_match);
    pair_bc <= 16'h0001;
    mem_i.mem[16'h2000] = 8'h5A;
    issue(oag_pkg::MODE_BLOCK, 8'hA8, 16'h0E00, 8'h01);
    chk("res_src_ptr", 16'h1FFF, res_src_ptr);
    chk("res_dst_ptr", 16'h3FFF, res_dst_ptr);
    chk("res_count_zero", 16'h0001, res_count_zero);
    chk("res_match", 16'h0001, res_match);
    $display("test block done");
    // reset lands while a slow two-byte fetch is still outstanding
    cmd_mode <= oag_pkg::MODE_IMM_EXT;
    cmd_pc <= 16'h0200;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("cmd_ready", 16'h0001, cmd_ready);
    chk("mem_req", 16'h0000, mem_req);
    chk("res_valid", 16'h0000, res_valid);
    run_row(rows[1]);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule
